// ==== common/srtf_pkg.sv ====
// Purpose: constants shared by the status record tail formatter
// Assumes: 25 MHz core clock, ASCII record positions 41 to 93
// Notes:   positions are the 1-based character positions of the record
package srtf_pkg;
	// clock and hold windows
	localparam int unsigned CLK_HZ          = 25_000_000;    // core clock rate
	localparam int unsigned SLIP_WINDOW_MS  = 3000;          // slip memory, ms
	localparam int unsigned REPLY_WINDOW_MS = 1000;          // reply memory, ms
	localparam int unsigned SLIP_HOLD_CYC   = (CLK_HZ / 1000) * SLIP_WINDOW_MS;
	localparam int unsigned REPLY_HOLD_CYC  = (CLK_HZ / 1000) * REPLY_WINDOW_MS;
	localparam int          TMR_W           = 27;            // holds 75e6

	// character positions (decimal in comments)
	localparam logic [6:0] POS_ENGAGED  = 7'h29;  // 41 engaged axes
	localparam logic [6:0] POS_ROLLMODE = 7'h2a;  // 42 roll mode
	localparam logic [6:0] POS_PITCHMD  = 7'h2c;  // 44 pitch mode
	localparam logic [6:0] POS_AXIS     = 7'h2e;  // 46 first servo field
	localparam logic [6:0] POS_AXIS_END = 7'h48;  // 72 last servo field
	localparam logic [6:0] POS_XSTATE   = 7'h49;  // 73 transponder state
	localparam logic [6:0] POS_XREPLY   = 7'h4a;  // 74 reply flag
	localparam logic [6:0] POS_XIDENT   = 7'h4b;  // 75 ident flag
	localparam logic [6:0] POS_SQUAWK   = 7'h4c;  // 76 first octal digit
	localparam logic [6:0] POS_SUM_HI   = 7'h5a;  // 90 checksum high nibble
	localparam logic [6:0] POS_SUM_LO   = 7'h5b;  // 91 checksum low nibble
	localparam logic [6:0] POS_CR       = 7'h5c;  // 92 carriage return
	localparam logic [6:0] POS_LF       = 7'h5d;  // 93 line feed
	localparam logic [6:0] AXIS_STRIDE  = 7'h09;  // chars per servo axis

	// ascii codes
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_PLUS  = 8'h2b;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_X     = 8'h58;
	localparam logic [7:0] CH_HEX_A = 8'h41;
	localparam logic [7:0] CH_CR    = 8'h0d;
	localparam logic [7:0] CH_LF    = 8'h0a;

	// value limits and decimal weights
	localparam logic [6:0]  FORCE_MAX = 7'h50;     // 80
	localparam logic [13:0] POS_MAX   = 14'h270f;  // 9999
	localparam logic [13:0] DIV_1000  = 14'h03e8;
	localparam logic [13:0] DIV_100   = 14'h0064;
	localparam logic [13:0] DIV_10    = 14'h000a;
	localparam logic [13:0] DIV_1     = 14'h0001;

	// axis indices; engaged digit bit weights follow them
	localparam int AX_ROLL  = 0;
	localparam int AX_PITCH = 1;
	localparam int AX_YAW   = 2;
endpackage : srtf_pkg

// ==== hw/srtf_formatter.sv ====
// Purpose: formats characters 41..93 of the system status record
// Assumes: all field inputs come from logic on core_clk; tx sink same clock
// Notes:   head formatter hands over its running sum of characters 1..40
// How it works
// - engaged digit is roll+2*pitch+4*yaw bit sum
// - no autopilot installed forces engaged digit zero
// - roll mode digit: heading, track, radio, satellite
// - roll disengaged zeroes roll mode, force, slip
// - pitch mode digit always zero, altitude hold
// - single reserved slots always send letter X
// - roll force: sign, two digits, clamp 80
// - roll position: sign, four digits, else XXXXX
// - slip flag one if slip within 3 s
// - pitch force: sign, two digits, clamp 80
// - pitch position: sign, four digits, else XXXXX
// - pitch disengaged zeroes pitch force and slip
// - yaw force: sign, two digits, clamp 80
// - yaw position: sign, four digits, else XXXXX
// - yaw disengaged zeroes yaw force and slip
// - transponder state digit: standby, ground, on, altitude
// - reply flag one if reply within 1 s
// - ident flag follows transponder ident report
// - ten reserved characters after code send X
// - checksum: 8-bit sum, two upper hex chars
// - record ends with carriage return, line feed
`timescale 1ns/100ps

module srtf_formatter
	import srtf_pkg::*;
#(
	parameter int unsigned SLIP_HOLD_CYCLES  = SLIP_HOLD_CYC,   // 3 s window
	parameter int unsigned REPLY_HOLD_CYCLES = REPLY_HOLD_CYC   // 1 s window
) (
	input  wire logic             core_clk,           // core clock, 25 MHz
	input  wire logic             rst_n,              // async reset, low active
	input  wire logic             rec_start,          // pulse: head done, start tail
	input  wire logic [7:0]       head_sum,           // sum of chars 1..40
	input  wire logic             autopilot_installed,// autopilot fitted
	input  wire logic [2:0]       autopilot_engaged,  // bit0 roll, 1 pitch, 2 yaw
	input  wire logic [1:0]       roll_mode,          // lateral mode code
	input  wire logic [2:0]       force_neg,          // force sign per axis
	input  wire logic [2:0][6:0]  force_mag,          // force magnitude per axis
	input  wire logic [2:0]       pos_valid,          // shaft position known
	input  wire logic [2:0]       pos_neg,            // position sign per axis
	input  wire logic [2:0][13:0] pos_mag,            // position steps per axis
	input  wire logic [2:0]       slip_evt,           // pulse: servo slipped
	input  wire logic [1:0]       xpdr_state,         // transponder state code
	input  wire logic             xpdr_reply_evt,     // pulse: reply sent
	input  wire logic             xpdr_ident,         // ident active level
	input  wire logic [11:0]      squawk_code,        // four octal digits
	input  wire logic             tx_ready,           // sink takes a byte
	output logic                  tx_valid,           // byte on tx_data
	output logic [7:0]            tx_data,            // ascii character
	output logic                  rec_busy,           // tail in progress
	output logic                  rec_done            // pulse: lf accepted
);

	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,   // waiting for head hand-over
		ST_SEND = 3'b010,   // loading characters 41..93
		ST_LAST = 3'b100    // line feed waiting for acceptance
	} srtf_state_e;

	srtf_state_e st_q;                                // sequencer state
	logic [6:0]  pos_q;                               // next position to load
	logic [7:0]  sum_q;                               // running checksum
	logic        tx_valid_q;                          // output byte valid
	logic [7:0]  tx_data_q;                           // output byte
	logic        done_q;                              // end of record pulse
	logic        busy_q;                              // record in progress
	logic        load;                                // load next character
	logic [7:0]  char_d;                              // character at pos_q

	// captured record fields
	logic [2:0]       eng_q;                          // engaged axes, masked
	logic [1:0]       rmode_q;                        // roll mode, masked
	logic [2:0]       fneg_q;                         // force sign
	logic [2:0][3:0]  ften_q;                         // force tens digit
	logic [2:0][3:0]  funit_q;                        // force units digit
	logic [2:0]       pok_q;                          // position available
	logic [2:0]       pneg_q;                         // position sign
	logic [2:0][15:0] pdig_q;                         // position bcd digits
	logic [2:0]       slip_q;                         // slip flag, masked
	logic [1:0]       xstate_q;                       // transponder state
	logic             xreply_q;                       // reply flag
	logic             xident_q;                       // ident flag
	logic [11:0]      squawk_q;                       // squawk code

	// hold timers
	logic [2:0][TMR_W-1:0] slip_tmr_q;                // per-axis slip memory
	logic [TMR_W-1:0]      reply_tmr_q;               // reply memory

	// servo field decode
	logic [6:0] rel;                                  // offset from position 46
	logic [1:0] ax;                                   // servo axis of rel
	logic [3:0] k;                                    // char within axis

	// one decimal digit of v at weight div
	function automatic logic [3:0] dec_dig(input logic [13:0] v, input logic [13:0] div);
		dec_dig = 4'((v / div) % DIV_10);
	endfunction : dec_dig

	// digit value to ascii
	function automatic logic [7:0] asc(input logic [3:0] d);
		asc = CH_ZERO + {4'h0, d};
	endfunction : asc

	// nibble to upper case hex ascii
	function automatic logic [7:0] hex(input logic [3:0] n);
		hex = (n < 4'ha) ? asc(n) : CH_HEX_A + {4'h0, n - 4'ha};
	endfunction : hex

	// a new character is loaded while the output slot is empty or drained
	// no bubble: a drained slot is refilled on the same edge
	assign load = (st_q == ST_SEND) && (!tx_valid_q || tx_ready);

	// sequencer: idle, send, wait for last byte
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q  <= ST_IDLE;
			pos_q <= POS_ENGAGED;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					// start is only heard here; busy states ignore it
					if (rec_start) begin              // head handed over
						st_q  <= ST_SEND;
						pos_q <= POS_ENGAGED;
					end
				end
				ST_SEND: begin
					if (load) begin
						pos_q <= pos_q + 7'h01;
						// the line feed is the last load of the record
						if (pos_q == POS_LF) begin
							st_q <= ST_LAST;
						end
					end
				end
				ST_LAST: begin
					// nothing new is loaded; wait for the sink
					if (tx_ready) begin               // line feed taken
						st_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// output byte register with valid/ready hold
	// the byte holds while the sink is not ready
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_q <= 1'b0;
			tx_data_q  <= 8'h00;
		end else if (load) begin
			tx_valid_q <= 1'b1;
			tx_data_q  <= char_d;
		end else if (tx_valid_q && tx_ready) begin
			tx_valid_q <= 1'b0;                       // drained, nothing next
		end
	end

	// running checksum over every byte before the checksum field
	// positions from 90 on are not summed, so the sum never counts itself
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sum_q <= 8'h00;
		end else if (st_q == ST_IDLE && rec_start) begin
			sum_q <= head_sum;
		end else if (load && pos_q < POS_SUM_HI) begin
			sum_q <= sum_q + char_d;
		end
	end

	// end of record pulse when the line feed is accepted
	// rec_done rises on the edge where busy falls
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (st_q == ST_LAST) && tx_ready;
		end
	end

	// busy flag: own flop so the port never shows a state decode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
		end else if (st_q == ST_IDLE && rec_start) begin
			busy_q <= 1'b1;                           // tail under way
		end else if (st_q == ST_LAST && tx_ready) begin
			busy_q <= 1'b0;                           // line feed taken
		end
	end

	// reply memory: reloads on each reply, flag while nonzero
	// a reply during the count restarts the full window
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reply_tmr_q <= '0;
		end else if (xpdr_reply_evt) begin
			reply_tmr_q <= TMR_W'(REPLY_HOLD_CYCLES);
		end else if (reply_tmr_q != '0) begin
			reply_tmr_q <= reply_tmr_q - TMR_W'(1);
		end
	end

	// non-axis fields captured once per record so the tail is consistent
	// timers are read here, so flags cover events before the start edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			eng_q    <= 3'h0;
			rmode_q  <= 2'h0;
			xstate_q <= 2'h0;
			xreply_q <= 1'b0;
			xident_q <= 1'b0;
			squawk_q <= 12'h000;
		end else if (st_q == ST_IDLE && rec_start) begin
			eng_q    <= autopilot_installed ? autopilot_engaged : 3'h0;
			rmode_q  <= (autopilot_installed && autopilot_engaged[AX_ROLL])
				? roll_mode : 2'h0;
			xstate_q <= xpdr_state;
			xreply_q <= (reply_tmr_q != '0);
			xident_q <= xpdr_ident;
			squawk_q <= squawk_code;
		end
	end

	// per-axis slip memory and servo field capture
	// axis index a is also the position of its bit in the engaged digit (weight 2**a)
	for (genvar a = 0; a < 3; a++) begin : g_axis
		logic        eng;                             // axis engaged
		logic [6:0]  fm;                              // clamped force
		logic [13:0] pm;                              // clamped position

		assign eng = autopilot_installed && autopilot_engaged[a];
		assign fm  = !eng ? 7'h00 : (force_mag[a] > FORCE_MAX) ? FORCE_MAX : force_mag[a];
		assign pm  = (pos_mag[a] > POS_MAX) ? POS_MAX : pos_mag[a];

		// slip memory: reloads on each slip, flag while nonzero
		// a slip during the count restarts the full window
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				slip_tmr_q[a] <= '0;
			end else if (slip_evt[a]) begin
				slip_tmr_q[a] <= TMR_W'(SLIP_HOLD_CYCLES);
			end else if (slip_tmr_q[a] != '0) begin
				slip_tmr_q[a] <= slip_tmr_q[a] - TMR_W'(1);
			end
		end

		// force, position and slip captured at record start
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				fneg_q[a]  <= 1'b0;
				ften_q[a]  <= 4'h0;
				funit_q[a] <= 4'h0;
				pok_q[a]   <= 1'b0;
				pneg_q[a]  <= 1'b0;
				pdig_q[a]  <= 16'h0000;
				slip_q[a]  <= 1'b0;
			end else if (st_q == ST_IDLE && rec_start) begin
				// disengaged axis sends +00 and slip 0
				fneg_q[a]  <= eng && force_neg[a];
				ften_q[a]  <= dec_dig({7'h00, fm}, DIV_10);
				funit_q[a] <= dec_dig({7'h00, fm}, DIV_1);
				pok_q[a]   <= pos_valid[a];
				pneg_q[a]  <= pos_neg[a];
				pdig_q[a]  <= {dec_dig(pm, DIV_1000), dec_dig(pm, DIV_100),
					dec_dig(pm, DIV_10), dec_dig(pm, DIV_1)};
				slip_q[a]  <= eng && (slip_tmr_q[a] != '0);
			end
		end
	end

	// servo field position split into axis and char index
	// ax and k mean something only for positions 46..72
	assign rel = pos_q - POS_AXIS;
	assign ax  = 2'(rel / AXIS_STRIDE);
	assign k   = 4'(rel % AXIS_STRIDE);

	// character for the current position; reserved slots default to X
	// anything not decoded below is a reserved slot
	always_comb begin
		char_d = CH_X;
		if (pos_q == POS_ENGAGED) begin
			char_d = asc({1'b0, eng_q});
		end else if (pos_q == POS_ROLLMODE) begin
			char_d = asc({2'h0, rmode_q});
		end else if (pos_q == POS_PITCHMD) begin
			char_d = CH_ZERO;
		end else if (pos_q >= POS_AXIS && pos_q <= POS_AXIS_END) begin
			case (k)
				4'h0: char_d = fneg_q[ax] ? CH_MINUS : CH_PLUS;   // force sign
				4'h1: char_d = asc(ften_q[ax]);
				4'h2: char_d = asc(funit_q[ax]);
				4'h3: begin                                       // position sign
					char_d = !pok_q[ax] ? CH_X : pneg_q[ax] ? CH_MINUS : CH_PLUS;
				end
				4'h4: char_d = pok_q[ax] ? asc(pdig_q[ax][15:12]) : CH_X;
				4'h5: char_d = pok_q[ax] ? asc(pdig_q[ax][11:8]) : CH_X;
				4'h6: char_d = pok_q[ax] ? asc(pdig_q[ax][7:4]) : CH_X;
				4'h7: char_d = pok_q[ax] ? asc(pdig_q[ax][3:0]) : CH_X;
				default: char_d = asc({3'h0, slip_q[ax]});        // slip flag
			endcase
		end else if (pos_q == POS_XSTATE) begin
			char_d = asc({2'h0, xstate_q});
		end else if (pos_q == POS_XREPLY) begin
			char_d = asc({3'h0, xreply_q});
		end else if (pos_q == POS_XIDENT) begin
			char_d = asc({3'h0, xident_q});
		end else if (pos_q >= POS_SQUAWK && pos_q < POS_SQUAWK + 7'h04) begin
			// most significant octal digit first
			case (2'(pos_q - POS_SQUAWK))
				2'h0: char_d = asc({1'b0, squawk_q[11:9]});
				2'h1: char_d = asc({1'b0, squawk_q[8:6]});
				2'h2: char_d = asc({1'b0, squawk_q[5:3]});
				default: char_d = asc({1'b0, squawk_q[2:0]});
			endcase
		end else if (pos_q == POS_SUM_HI) begin
			char_d = hex(sum_q[7:4]);
		end else if (pos_q == POS_SUM_LO) begin
			char_d = hex(sum_q[3:0]);
		end else if (pos_q == POS_CR) begin
			char_d = CH_CR;
		end else if (pos_q == POS_LF) begin
			char_d = CH_LF;
		end
	end

	// outputs straight from flops
	// rec_busy has its own flop rather than a state decode
	assign tx_valid = tx_valid_q;
	assign tx_data  = tx_data_q;
	assign rec_busy = busy_q;
	assign rec_done = done_q;

endmodule : srtf_formatter

// ==== sim/srtf_formatter_props.sv ====
// Purpose: port-level checks of the status record tail formatter
// Assumes: single core_clk domain, rst_n async active low
// Notes:   byte counter tracks position 41 + cnt_q
`timescale 1ns/100ps

module srtf_formatter_props
	import srtf_pkg::*;
(
	input wire logic       core_clk,            // core clock
	input wire logic       rst_n,               // async reset
	input wire logic       rec_start,           // start pulse
	input wire logic [7:0] head_sum,            // head checksum
	input wire logic       autopilot_installed, // autopilot fitted
	input wire logic [2:0] autopilot_engaged,   // engaged axes
	input wire logic       tx_ready,            // sink ready
	input wire logic       tx_valid,            // byte valid
	input wire logic [7:0] tx_data,             // ascii byte
	input wire logic       rec_busy,            // record running
	input wire logic       rec_done             // record finished
);
	logic       acc;    // byte accepted this edge
	logic [6:0] cnt_q;  // bytes accepted in record
	logic [7:0] sum_q;  // running checksum
	logic [2:0] eng_q;  // masked engaged axes
	logic [7:0] hi_chr; // expected high hex char

	assign acc = tx_valid && tx_ready;

	// position, sum and engaged capture per record
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 7'h00;
			sum_q <= 8'h00;
			eng_q <= 3'h0;
		end else if (rec_start && !rec_busy) begin
			cnt_q <= 7'h00;
			sum_q <= head_sum;
			eng_q <= autopilot_installed ? autopilot_engaged : 3'h0;
		end else if (acc) begin
			cnt_q <= cnt_q + 7'h01;
			if (cnt_q < 7'h31) sum_q <= sum_q + tx_data;
		end
	end

	// upper case hex of the high nibble
	always_comb begin
		if (sum_q[7:4] < 4'ha) hi_chr = CH_ZERO + {4'h0, sum_q[7:4]};
		else hi_chr = CH_HEX_A + {4'h0, sum_q[7:4]} - 8'h0a;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_start_answer: assert property (
		rec_start && !rec_busy |=> rec_busy && !tx_valid ##1 (tx_valid && cnt_q == 7'h00))
		else $error("first byte not offered after start");
	a_hold_byte: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("byte changed before acceptance");
	a_idle_quiet: assert property (!rec_busy |-> !tx_valid)
		else $error("byte offered outside a record");
	a_engaged_digit: assert property (
		acc && cnt_q == 7'h00 |-> tx_data == CH_ZERO + {5'h00, eng_q})
		else $error("engaged digit wrong");
	a_reserved_x: assert property (
		acc && (cnt_q == 7'h02 || cnt_q == 7'h04 || (cnt_q >= 7'h27 && cnt_q <= 7'h30))
		|-> tx_data == CH_X)
		else $error("reserved slot not X");
	a_pitch_mode: assert property (acc && cnt_q == 7'h03 |-> tx_data == CH_ZERO)
		else $error("pitch mode not zero");
	a_squawk_octal: assert property (
		acc && cnt_q >= 7'h23 && cnt_q <= 7'h26 |-> tx_data[7:3] == 5'h06)
		else $error("squawk digit not octal");
	a_sum_high: assert property (acc && cnt_q == 7'h31 |-> tx_data == hi_chr)
		else $error("checksum high char wrong");
	a_cr_lf: assert property (
		acc && cnt_q == 7'h33 |-> tx_data == CH_CR ##1 (tx_valid && tx_data == CH_LF))
		else $error("terminator order wrong");
	a_lf_done: assert property (
		acc && cnt_q == 7'h34 |=> rec_done && !tx_valid && !rec_busy && cnt_q == 7'h35)
		else $error("record end not flagged");

	c_done: cover property (rec_done);
	c_stall: cover property (tx_valid && !tx_ready);
	c_refused: cover property (rec_start && rec_busy);
endmodule : srtf_formatter_props

bind srtf_formatter srtf_formatter_props chk_u (.core_clk(core_clk), .rst_n(rst_n),
	.rec_start(rec_start), .head_sum(head_sum), .autopilot_installed(autopilot_installed),
	.autopilot_engaged(autopilot_engaged), .tx_ready(tx_ready), .tx_valid(tx_valid),
	.tx_data(tx_data), .rec_busy(rec_busy), .rec_done(rec_done));

// ==== sim/srtf_rx_model.sv ====
// Purpose: serial sink that stores one record by position
// Assumes: bytes taken on rising edge with valid and ready
// Notes:   slow mode stalls every other cycle
`timescale 1ns/100ps

module srtf_rx_model (
	input  wire logic       core_clk, // core clock
	input  wire logic       rst_n,    // async reset
	input  wire logic       slow,     // stall every other cycle
	input  wire logic       tx_valid, // byte offered
	input  wire logic [7:0] tx_data,  // byte value
	output logic            tx_ready  // byte taken
);
	logic [7:0] rec_q [41:93]; // received record, by position
	logic [6:0] pos_q;         // next position to fill

	// ready changes only off the sampling edge; high outside slow mode
	always @(negedge core_clk) tx_ready <= (slow && tx_ready === 1'b1) ? 1'b0 : 1'b1;

	// reserved slots are stored raw and never decoded
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_q <= 7'h29;
		end else if (tx_valid && tx_ready) begin
			rec_q[pos_q] <= tx_data;
			pos_q <= (pos_q == 7'h5d) ? 7'h29 : pos_q + 7'h01;
		end
	end
endmodule : srtf_rx_model

// ==== sim/tb.sv ====
// Purpose: self-checking bench of the status record tail formatter
// Assumes: short slip and reply windows of 40 and 20 cycles
// Notes:   expected record built from the inputs before each start
`timescale 1ns/100ps

module tb;
	import srtf_pkg::*;
	logic             core_clk = 1'b0, rst_n = 1'b0, rec_start = 1'b0, slow = 1'b0;
	logic             autopilot_installed = 1'b1, xpdr_reply_evt = 1'b0, xpdr_ident = 1'b0;
	logic [7:0]       head_sum = 8'h00;
	logic [2:0]       autopilot_engaged = 3'h0, force_neg = 3'h0, pos_valid = 3'h7;
	logic [2:0]       pos_neg = 3'h0, slip_evt = 3'h0;
	logic [1:0]       roll_mode = 2'h0, xpdr_state = 2'h0;
	logic [2:0][6:0]  force_mag = '0;
	logic [2:0][13:0] pos_mag = '0;
	logic [11:0]      squawk_code = 12'h000;
	logic             tx_ready, tx_valid, rec_busy, rec_done;
	logic [7:0]       tx_data;
	logic [7:0]       exp_q [41:93]; // expected record
	int               errors = 0, n_compared = 0, cyc = 0;

	srtf_formatter #(.SLIP_HOLD_CYCLES(40), .REPLY_HOLD_CYCLES(20)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .rec_start(rec_start), .head_sum(head_sum),
		.autopilot_installed(autopilot_installed), .autopilot_engaged(autopilot_engaged),
		.roll_mode(roll_mode), .force_neg(force_neg), .force_mag(force_mag),
		.pos_valid(pos_valid), .pos_neg(pos_neg), .pos_mag(pos_mag), .slip_evt(slip_evt),
		.xpdr_state(xpdr_state), .xpdr_reply_evt(xpdr_reply_evt), .xpdr_ident(xpdr_ident),
		.squawk_code(squawk_code), .tx_ready(tx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .rec_busy(rec_busy), .rec_done(rec_done));
	srtf_rx_model rx_u (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	always #20 core_clk = ~core_clk;

	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			end_sim();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? CH_ZERO + {4'h0, n} : CH_HEX_A + {4'h0, n} - 8'h0a;
	endfunction : hx

	// expected characters 41..93 from current inputs
	function automatic void build(input logic [2:0] slp, input logic rep);
		logic [2:0] eng;
		logic [6:0] f;
		logic [13:0] p;
		logic [7:0] sum;
		int b;
		eng = autopilot_installed ? autopilot_engaged : 3'h0;
		exp_q[41] = CH_ZERO + {5'h00, eng};
		exp_q[42] = eng[0] ? CH_ZERO + {6'h00, roll_mode} : CH_ZERO;
		exp_q[43] = CH_X;
		exp_q[44] = CH_ZERO;
		exp_q[45] = CH_X;
		for (int a = 0; a < 3; a++) begin
			b = 46 + 9 * a;
			f = (force_mag[a] > FORCE_MAX) ? FORCE_MAX : force_mag[a];
			p = (pos_mag[a] > POS_MAX) ? POS_MAX : pos_mag[a];
			exp_q[b] = (eng[a] && force_neg[a]) ? CH_MINUS : CH_PLUS;
			exp_q[b+1] = eng[a] ? CH_ZERO + 8'(f / 10) : CH_ZERO;
			exp_q[b+2] = eng[a] ? CH_ZERO + 8'(f % 10) : CH_ZERO;
			exp_q[b+3] = !pos_valid[a] ? CH_X : (pos_neg[a] ? CH_MINUS : CH_PLUS);
			for (int k = 0; k < 4; k++)
				exp_q[b+4+k] = pos_valid[a] ? CH_ZERO + 8'((p / (10 ** (3 - k))) % 10) : CH_X;
			exp_q[b+8] = CH_ZERO + {7'h00, eng[a] && slp[a]};
		end
		exp_q[73] = CH_ZERO + {6'h00, xpdr_state};
		exp_q[74] = CH_ZERO + {7'h00, rep};
		exp_q[75] = CH_ZERO + {7'h00, xpdr_ident};
		for (int k = 0; k < 4; k++) exp_q[76+k] = CH_ZERO + {5'h00, squawk_code[11-3*k -: 3]};
		for (int k = 80; k < 90; k++) exp_q[k] = CH_X;
		sum = head_sum;
		for (int k = 41; k < 90; k++) sum = sum + exp_q[k];
		exp_q[90] = hx(sum[7:4]);
		exp_q[91] = hx(sum[3:0]);
		exp_q[92] = CH_CR;
		exp_q[93] = CH_LF;
	endfunction : build

	// one record, with a refused start and a head_sum change mid-record
	task automatic run_rec(input logic [2:0] slp, input logic rep);
		build(slp, rep);
		@(negedge core_clk) rec_start = 1'b1;
		@(negedge core_clk) rec_start = 1'b0;
		repeat (3) @(negedge core_clk);
		chk({7'h00, rec_busy}, 8'h01);
		rec_start = 1'b1;
		head_sum = ~head_sum;
		@(negedge core_clk) rec_start = 1'b0;
		for (int i = 0; i < 400 && rec_done !== 1'b1; i++) @(negedge core_clk);
		chk({7'h00, rec_done}, 8'h01);
		chk({7'h00, rec_busy}, 8'h00);
		head_sum = ~head_sum;
		for (int k = 41; k < 94; k++) chk(rx_u.rec_q[k], exp_q[k]);
		repeat (4) @(negedge core_clk) chk({7'h00, tx_valid}, 8'h00);
	endtask : run_rec

	task automatic t_codes;
		for (int e = 0; e < 8; e++) begin
			autopilot_engaged = 3'(e);
			roll_mode = 2'(e >> 1);
			xpdr_state = 2'(e);
			force_neg = 3'(e) ^ 3'h5;
			force_mag = {7'(e * 11), 7'(e * 3), 7'(e * 7)};
			squawk_code = 12'(e * 12'h249);
			head_sum = 8'(e * 37);
			run_rec(3'h0, 1'b0);
		end
		$display("done: engaged, mode and state codes");
	endtask : t_codes

	task automatic t_no_ap;
		@(negedge core_clk) autopilot_installed = 1'b0;
		autopilot_engaged = 3'h7;
		run_rec(3'h0, 1'b0);
		autopilot_installed = 1'b1;
		$display("done: no autopilot");
	endtask : t_no_ap

	task automatic t_limits;
		@(negedge core_clk) slow = 1'b1;
		autopilot_engaged = 3'h7;
		force_neg = 3'h2;
		force_mag = {7'h51, 7'h50, 7'h00};
		pos_valid = 3'h5;
		pos_neg = 3'h5;
		pos_mag = {14'h270f, 14'h2710, 14'h0320};
		run_rec(3'h0, 1'b0);
		pos_valid = 3'h2;
		run_rec(3'h0, 1'b0);
		slow = 1'b0;
		$display("done: limits and stalls");
	endtask : t_limits

	task automatic t_flags;
		@(negedge core_clk) slip_evt = 3'h7;
		xpdr_reply_evt = 1'b1;
		xpdr_ident = 1'b1;
		@(negedge core_clk) slip_evt = 3'h0;
		xpdr_reply_evt = 1'b0;
		repeat (5) @(negedge core_clk);
		run_rec(3'h7, 1'b1);
		xpdr_ident = 1'b0;
		repeat (10) @(negedge core_clk);
		run_rec(3'h0, 1'b0);
		$display("done: slip, reply and ident flags");
	endtask : t_flags

	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	initial begin
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		t_codes();
		t_no_ap();
		t_limits();
		t_flags();
		end_sim();
	end
endmodule : tb
